// file: csss_core.sv
// Overview of operation
// - power-down release with stop off gives settled output within 3 ms
// - power-down release into clock-stop has source settled within 3 ms
// - after supply is stable, normal output settles within 3 ms
// - after supply is stable, source settles within 3 ms for stop or test
// - ratio select change in normal mode resettles output within 1 ms
// - output may glitch only 10 ns after output-stop release
// - within 20 output cycles phase returns within 50 ps, full spec after
// - output-stop asserted in normal disables outputs within 5 ns; here one 10 ns core cycle after the synchronized pin
// - clock-stop state holds both outputs high-impedance
// - output mode change between test and normal resettles within 3 ms
// - power-down asserted from normal or stop reaches power-down in 1 ms
// - distributed loop locks within 5 ms after output settles
// - power-down pin low sleeps; else stop low stops, stop high runs
// - mode 00 aligned, 01 both high-impedance, 10 bypass, 11 reference
// - locked loop keeps rising-edge phase error within 100 ps
//
// Local design decisions: the register addresses and register access over APB.
module csss_core
  import csss_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_SETTLE_CYC,
  parameter int RATIO_CYC = RATIO_SETTLE_CYC,
  parameter int SELECT_CYC = SELECT_SETTLE_CYC,
  parameter int LOCK_CYC = LOOP_LOCK_CYC
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic power_down_n_i,
  input wire logic output_stop_n_i,
  input wire logic pll_ratio_sel0_i,
  input wire logic pll_ratio_sel1_i,
  input wire logic out_mode_sel0_i,
  input wire logic out_mode_sel1_i,
  input wire logic ctrl_phase_ref_i,
  input wire logic chan_phase_ref_i,
  input wire logic ref_clk_i,
  input wire csss_apb_req_s apb_req_i,
  output csss_apb_rsp_s apb_rsp_o,
  output logic chan_clk_o,
  output logic chan_clk_n_o,
  output logic chan_clk_oe_n_o,
  output logic settled_o,
  output logic locked_o
);

  csss_core_s r_reg;
  csss_core_s r_next;
  csss_pins_s pins_raw;
  csss_pins_s pins;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic [TMR_W-1:0] tmr_cnt;
  logic tmr_done;
  logic lock_load;
  logic lock_done;
  logic pd_eff;
  logic ratio_chg;
  logic mode_chg;
  logic ctrl_rise;
  logic chan_rise;
  logic slip;
  logic div_rise;
  logic drive;
  logic src;
  logic [2:0] half;

  function automatic logic [2:0] half_period(input logic [1:0] ratio);
    case (ratio)
      2'h0: half_period = HALF_R0;
      2'h1: half_period = HALF_R1;
      2'h2: half_period = HALF_R2;
      default: half_period = HALF_R3;
    endcase
  endfunction : half_period

  assign pins_raw = '{power_down_n: power_down_n_i,
    output_stop_n: output_stop_n_i,
    ratio: {pll_ratio_sel0_i, pll_ratio_sel1_i},
    mode: {out_mode_sel0_i, out_mode_sel1_i},
    ctrl_phase_ref: ctrl_phase_ref_i,
    chan_phase_ref: chan_phase_ref_i,
    ref_clk: ref_clk_i};

  csss_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  csss_timer u_settle_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .load_i(tmr_load),
    .val_i(tmr_val),
    .cnt_o(tmr_cnt),
    .done_o(tmr_done)
  );

  csss_timer u_lock_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .load_i(lock_load),
    .val_i(TMR_W'(LOCK_CYC - 1)),
    .cnt_o(),
    .done_o(lock_done)
  );

  always_comb
  begin
    r_next = r_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    slip = 1'b0;
    src = 1'b0;
    // pin or software sleep forces power-down
    pd_eff = pins.power_down_n & ~r_reg.sw_sleep;
    ratio_chg = (pins.ratio != r_reg.ratio_q);
    mode_chg = (pins.mode != r_reg.mode_q);
    ctrl_rise = pins.ctrl_phase_ref & ~r_reg.ctrl_q;
    chan_rise = pins.chan_phase_ref & ~r_reg.chan_q;
    half = half_period(r_reg.ratio_q);
    r_next.ratio_q = pins.ratio;
    r_next.mode_q = pins.mode;
    r_next.ctrl_q = pins.ctrl_phase_ref;
    r_next.chan_q = pins.chan_phase_ref;

    if (r_reg.st == ST_RUN && r_reg.loop_en &&
        r_reg.mode_q == MODE_NORMAL && (ctrl_rise || chan_rise))
    begin
      if (ctrl_rise && chan_rise)
      begin
        if (r_reg.hits != LOCK_HITS)
          r_next.hits = r_reg.hits + 4'h1;
      end
      else
      begin
        r_next.hits = 4'h0;
        // only a lone channel edge holds the divider one cycle
        slip = chan_rise;
      end
    end
    else if (r_reg.st != ST_RUN)
      r_next.hits = 4'h0;
    r_next.locked = (r_next.hits == LOCK_HITS);
    // lock timeout flag once the lock window expires
    if (r_reg.st != ST_RUN || r_next.locked || !r_reg.loop_en)
      r_next.lock_to = 1'b0;
    else if (lock_done)
      r_next.lock_to = 1'b1;

    // clock source; bypass ignores the aligner
    if (r_reg.st == ST_SLEEP)
    begin
      r_next.div_cnt = 3'h0;
      r_next.div_clk = 1'b0;
    end
    else if (!(slip && r_reg.mode_q == MODE_NORMAL))
    begin
      if (r_reg.div_cnt >= half - 3'h1)
      begin
        r_next.div_cnt = 3'h0;
        r_next.div_clk = ~r_reg.div_clk;
      end
      else
        r_next.div_cnt = r_reg.div_cnt + 3'h1;
    end
    div_rise = r_next.div_clk & ~r_reg.div_clk;

    case (r_reg.st)
      ST_SLEEP:
      begin
        // supply-on and wake share the same settle
        if (pd_eff)
        begin
          r_next.st = ST_WAKE;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(WAKE_CYC - 1);
        end
      end
      ST_WAKE:
      begin
        // leave settle time toward run or stop
        if (tmr_done)
          r_next.st = pins.output_stop_n ? ST_RUN : ST_STOP;
      end
      ST_STOP:
      begin
        if (pins.output_stop_n)
        begin
          r_next.st = ST_ENABLE;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(OUT_ENABLE_CYC - 1);
        end
      end
      ST_ENABLE:
      begin
        // glitch window bounded by the enable time
        if (!pins.output_stop_n)
          r_next.st = ST_STOP;
        else if (tmr_done)
        begin
          r_next.st = ST_RESETTLE;
          r_next.edge_cnt = 5'h00;
        end
      end
      ST_RESETTLE:
      begin
        // count output cycles until phase is settled
        if (!pins.output_stop_n)
          r_next.st = ST_STOP;
        else if (div_rise)
        begin
          r_next.edge_cnt = r_reg.edge_cnt + 5'h01;
          if (r_reg.edge_cnt == RESETTLE_EDGES - 5'h01)
            r_next.st = ST_RUN;
        end
      end
      ST_RUN, ST_RETUNE:
      begin
        // stop request disables the outputs next cycle
        if (!pins.output_stop_n)
          r_next.st = ST_STOP;
        // select change restarts the select settle
        else if (mode_chg)
        begin
          r_next.st = ST_RETUNE;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(SELECT_CYC - 1);
        end
        // ratio change restarts the ratio settle
        else if (ratio_chg)
        begin
          r_next.st = ST_RETUNE;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(RATIO_CYC - 1);
        end
        else if (r_reg.st == ST_RETUNE && tmr_done)
          r_next.st = ST_RUN;
      end
      default:
        r_next.st = ST_SLEEP;
    endcase

    // power-down wins over every other state
    if (!pd_eff)
      r_next.st = ST_SLEEP;
    // lock drops as soon as run is left
    if (r_next.st != ST_RUN)
      r_next.hits = 4'h0;
    r_next.locked = (r_next.hits == LOCK_HITS);

    // drive only in enabled states and non-hiz modes
    drive = (r_next.st == ST_ENABLE || r_next.st == ST_RESETTLE ||
             r_next.st == ST_RUN || r_next.st == ST_RETUNE) &&
            r_next.mode_q != MODE_HIZ;
    case (r_next.mode_q)
      MODE_TEST: src = pins.ref_clk;
      default: src = r_next.div_clk;
    endcase
    if (r_next.st == ST_SLEEP)
    begin
      r_next.oe_n_q = 1'b0;
      r_next.clk_q = 1'b0;
      r_next.clk_n_q = 1'b0;
    end
    else
    begin
      r_next.oe_n_q = ~drive;
      r_next.clk_q = drive & src;
      r_next.clk_n_q = drive & ~src;
    end

    // APB: read data captured in setup, writes at access
    if (apb_req_i.psel && !apb_req_i.penable)
    begin
      r_next.pslverr = 1'b0;
      case (apb_req_i.paddr)
        ADDR_CTRL:
          r_next.prdata = {30'h0, r_reg.loop_en, r_reg.sw_sleep};
        ADDR_STATUS:
          r_next.prdata = {22'h0, r_reg.lock_to, r_reg.locked,
                           r_reg.st == ST_RUN, r_reg.st};
        ADDR_PINS:
          r_next.prdata = {23'h0, pins};
        default:
        begin
          r_next.prdata = 32'h0000_0000;
          r_next.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite &&
        apb_req_i.paddr == ADDR_CTRL)
    begin
      r_next.sw_sleep = apb_req_i.pwdata[CTRL_SW_SLEEP_BIT];
      r_next.loop_en = apb_req_i.pwdata[CTRL_LOOP_EN_BIT];
    end
  end

  assign lock_load = (r_next.st == ST_RUN) && (r_reg.st != ST_RUN);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      r_reg <= CORE_RESET;
    else if (clk_en_i)
      r_reg <= r_next;
  end

  assign apb_rsp_o = '{pready: 1'b1, prdata: r_reg.prdata,
                       pslverr: r_reg.pslverr};
  assign chan_clk_o = r_reg.clk_q;
  assign chan_clk_n_o = r_reg.clk_n_q;
  assign chan_clk_oe_n_o = r_reg.oe_n_q;
  // settled and locked flags for the controller
  assign settled_o = (r_reg.st == ST_RUN);
  assign locked_o = r_reg.locked;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sleep_entry_a: assert property (
    (clk_en_i && !pd_eff) |=> (r_reg.st == ST_SLEEP))
    else $error("power-down not entered");

  sleep_ground_a: assert property (
    (r_reg.st == ST_SLEEP) |->
      (!chan_clk_oe_n_o && !chan_clk_o && !chan_clk_n_o))
    else $error("outputs not grounded in sleep");

  stop_hiz_a: assert property (
    (r_reg.st == ST_STOP) |-> chan_clk_oe_n_o)
    else $error("outputs driven in clock-stop");

  out_disable_a: assert property (
    (clk_en_i && pd_eff && r_reg.st == ST_RUN && !pins.output_stop_n)
      |=> (r_reg.st == ST_STOP && chan_clk_oe_n_o))
    else $error("output not disabled one cycle after stop");

  wake_load_a: assert property (
    $rose(r_reg.st == ST_WAKE) |-> (tmr_cnt == TMR_W'(WAKE_CYC - 1)))
    else $error("wake settle time wrong");

  ratio_retune_a: assert property (
    (clk_en_i && pd_eff && r_reg.st == ST_RUN && pins.output_stop_n &&
     ratio_chg && !mode_chg)
      |=> (r_reg.st == ST_RETUNE && tmr_cnt == TMR_W'(RATIO_CYC - 1)))
    else $error("ratio change did not start retune");

  mode_retune_a: assert property (
    (clk_en_i && pd_eff && r_reg.st == ST_RUN && pins.output_stop_n &&
     mode_chg)
      |=> (r_reg.st == ST_RETUNE && tmr_cnt == TMR_W'(SELECT_CYC - 1)))
    else $error("mode change did not start retune");

  enable_window_a: assert property (
    (clk_en_i && r_reg.st == ST_ENABLE) |=> (r_reg.st != ST_ENABLE))
    else $error("glitch window too long");

  hiz_mode_a: assert property (
    (r_reg.st != ST_SLEEP && r_reg.mode_q == MODE_HIZ) |-> chan_clk_oe_n_o)
    else $error("hiz mode drives outputs");

  resettle_count_a: assert property (
    (r_reg.st == ST_RESETTLE) |-> (r_reg.edge_cnt < RESETTLE_EDGES))
    else $error("resettle ran past its cycle count");

  lock_flag_a: assert property (
    locked_o |-> (r_reg.hits == LOCK_HITS && r_reg.st == ST_RUN))
    else $error("locked without aligned edges");

  wake_cov_c: cover property (
    (r_reg.st == ST_WAKE) ##1 (r_reg.st == ST_RUN));
  stop_cov_c: cover property (
    (r_reg.st == ST_RUN) ##1 (r_reg.st == ST_STOP));
  restart_cov_c: cover property (
    (r_reg.st == ST_RESETTLE) ##1 (r_reg.st == ST_RUN));
  retune_cov_c: cover property (
    (r_reg.st == ST_RETUNE) ##1 (r_reg.st == ST_RUN));
  lock_cov_c: cover property ($rose(locked_o));

endmodule : csss_core

// file: csss_pkg.sv
package csss_pkg;

  localparam int CORE_CLK_MHZ = 100;
  localparam int CORE_CLK_PERIOD_NS = 10;

  // settle times in their own units
  localparam int T_WAKE_SETTLE_MS = 3;
  localparam int T_RATIO_SETTLE_MS = 1;
  localparam int T_SELECT_SETTLE_MS = 3;
  localparam int T_LOOP_LOCK_MS = 5;
  localparam int T_SLEEP_ENTRY_MS = 1;
  localparam int T_OUT_ENABLE_NS = 10;
  localparam int T_OUT_DISABLE_NS = 5;
  localparam int T_PHASE_RESETTLE_OUTCYC = 20;

  // shortest times round down, never below one cycle
  localparam int WAKE_SETTLE_CYC = T_WAKE_SETTLE_MS * 1000 * CORE_CLK_MHZ;
  localparam int RATIO_SETTLE_CYC = T_RATIO_SETTLE_MS * 1000 * CORE_CLK_MHZ;
  localparam int SELECT_SETTLE_CYC = T_SELECT_SETTLE_MS * 1000 * CORE_CLK_MHZ;
  localparam int LOOP_LOCK_CYC = T_LOOP_LOCK_MS * 1000 * CORE_CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC = T_SLEEP_ENTRY_MS * 1000 * CORE_CLK_MHZ;
  localparam int OUT_ENABLE_CYC =
    (T_OUT_ENABLE_NS / CORE_CLK_PERIOD_NS) < 1 ? 1 :
    (T_OUT_ENABLE_NS / CORE_CLK_PERIOD_NS);
  localparam int OUT_DISABLE_CYC =
    (T_OUT_DISABLE_NS / CORE_CLK_PERIOD_NS) < 1 ? 1 :
    (T_OUT_DISABLE_NS / CORE_CLK_PERIOD_NS);

  localparam int TMR_W = 20;
  localparam logic [4:0] RESETTLE_EDGES = 5'(T_PHASE_RESETTLE_OUTCYC);
  localparam logic [3:0] LOCK_HITS = 4'h8;

  // output source select, coded {sel0, sel1}
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HIZ = 2'h1;
  localparam logic [1:0] MODE_BYPASS = 2'h2;
  localparam logic [1:0] MODE_TEST = 2'h3;

  // divider half periods per ratio code {sel0, sel1}
  localparam logic [2:0] HALF_R0 = 3'h2;
  localparam logic [2:0] HALF_R1 = 3'h3;
  localparam logic [2:0] HALF_R2 = 3'h5;
  localparam logic [2:0] HALF_R3 = 3'h4;

  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PINS = 8'h08;
  localparam int CTRL_SW_SLEEP_BIT = 0;
  localparam int CTRL_LOOP_EN_BIT = 1;
  localparam int STAT_SETTLED_BIT = 7;
  localparam int STAT_LOCKED_BIT = 8;
  localparam int STAT_LOCK_TO_BIT = 9;

  typedef enum logic [6:0] {
    ST_SLEEP = 7'h01,
    ST_WAKE = 7'h02,
    ST_STOP = 7'h04,
    ST_ENABLE = 7'h08,
    ST_RESETTLE = 7'h10,
    ST_RUN = 7'h20,
    ST_RETUNE = 7'h40
  } csss_state_e;

  typedef struct packed {
    logic power_down_n;
    logic output_stop_n;
    logic [1:0] ratio;
    logic [1:0] mode;
    logic ctrl_phase_ref;
    logic chan_phase_ref;
    logic ref_clk;
  } csss_pins_s;

  localparam csss_pins_s PINS_RESET = '0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } csss_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } csss_apb_rsp_s;

  typedef struct packed {
    csss_state_e st;
    logic [1:0] ratio_q;
    logic [1:0] mode_q;
    logic [2:0] div_cnt;
    logic div_clk;
    logic ctrl_q;
    logic chan_q;
    logic [4:0] edge_cnt;
    logic [3:0] hits;
    logic locked;
    logic lock_to;
    logic sw_sleep;
    logic loop_en;
    logic clk_q;
    logic clk_n_q;
    logic oe_n_q;
    logic [31:0] prdata;
    logic pslverr;
  } csss_core_s;

  localparam csss_core_s CORE_RESET = '{
    st: ST_SLEEP, ratio_q: 2'h0, mode_q: 2'h0, div_cnt: 3'h0,
    div_clk: 1'b0, ctrl_q: 1'b0, chan_q: 1'b0, edge_cnt: 5'h00,
    hits: 4'h0, locked: 1'b0, lock_to: 1'b0, sw_sleep: 1'b0,
    loop_en: 1'b1, clk_q: 1'b0, clk_n_q: 1'b0, oe_n_q: 1'b0,
    prdata: 32'h0000_0000, pslverr: 1'b0};

endpackage : csss_pkg

// file: csss_sync.sv
module csss_sync
  import csss_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire csss_pins_s d_i,
  output csss_pins_s q_o
);

  typedef struct packed {
    csss_pins_s s1;
    csss_pins_s s2;
  } csss_sync_s;

  csss_sync_s r_reg;
  csss_sync_s r_next;

  always_comb
  begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      r_reg <= '{s1: PINS_RESET, s2: PINS_RESET};
    else if (clk_en_i)
      r_reg <= r_next;
  end

  assign q_o = r_reg.s2;

endmodule : csss_sync

// file: csss_timer.sv
module csss_timer
  import csss_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic load_i,
  input wire logic [TMR_W-1:0] val_i,
  output logic [TMR_W-1:0] cnt_o,
  output logic done_o
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } csss_tmr_s;

  csss_tmr_s r_reg;
  csss_tmr_s r_next;

  always_comb
  begin
    r_next = r_reg;
    if (load_i)
      r_next.cnt = val_i;
    else if (r_reg.cnt != '0)
      r_next.cnt = r_reg.cnt - 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      r_reg <= '{cnt: '0};
    else if (clk_en_i)
      r_reg <= r_next;
  end

  assign cnt_o = r_reg.cnt;
  assign done_o = (r_reg.cnt == '0);

endmodule : csss_timer

// file: csss_ctrl_model.sv
module csss_ctrl_model
  import csss_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pd_n_i,
  input wire logic stop_n_i,
  input wire logic [1:0] ratio_i,
  input wire logic [1:0] mode_i,
  input wire logic chan_clk_i,
  input wire logic chan_clk_oe_n_i,
  output csss_pins_s pins_o
);
  logic [1:0] div_cnt;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pins_o <= PINS_RESET;
      div_cnt <= 2'h0;
    end
    else
    begin
      div_cnt <= div_cnt + 2'h1;
      pins_o.power_down_n <= pd_n_i;
      pins_o.output_stop_n <= stop_n_i;
      pins_o.ratio <= ratio_i;
      if (!pins_o.power_down_n && !pd_n_i)
        pins_o.mode <= mode_i;
      // gear divider matching ratio code zero
      pins_o.ctrl_phase_ref <= div_cnt[1];
      // channel side reference, quiet while undriven
      pins_o.chan_phase_ref <= chan_clk_i & ~chan_clk_oe_n_i;
      pins_o.ref_clk <= ~pins_o.ref_clk;
    end
  end
endmodule : csss_ctrl_model

// file: clock_source_state_sequencer_bench.sv
module clock_source_state_sequencer_bench
  import csss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAKE_P = 50;
  localparam int RATIO_P = 30;
  localparam int SELECT_P = 40;
  localparam int LOCK_P = 200;

  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  csss_apb_req_s req = '0;
  csss_apb_rsp_s rsp;
  logic pd_n = 1'b0;
  logic stop_n = 1'b0;
  logic [1:0] ratio = 2'h0;
  logic [1:0] mode = 2'h0;
  csss_pins_s pins;
  logic chan_clk, chan_clk_n, oe_n, settled, locked;
  logic [31:0] rd;
  logic err;
  logic [2:0] halfs [4] = '{HALF_R0, HALF_R1, HALF_R2, HALF_R3};
  int fail_count = 0;
  int checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  csss_ctrl_model ctrl_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .pd_n_i(pd_n), .stop_n_i(stop_n), .ratio_i(ratio), .mode_i(mode),
    .chan_clk_i(chan_clk), .chan_clk_oe_n_i(oe_n), .pins_o(pins));

  csss_core #(.WAKE_CYC(WAKE_P), .RATIO_CYC(RATIO_P),
    .SELECT_CYC(SELECT_P), .LOCK_CYC(LOCK_P)) dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .power_down_n_i(pins.power_down_n),
    .output_stop_n_i(pins.output_stop_n),
    .pll_ratio_sel0_i(pins.ratio[1]), .pll_ratio_sel1_i(pins.ratio[0]),
    .out_mode_sel0_i(pins.mode[1]), .out_mode_sel1_i(pins.mode[0]),
    .ctrl_phase_ref_i(pins.ctrl_phase_ref),
    .chan_phase_ref_i(pins.chan_phase_ref), .ref_clk_i(pins.ref_clk),
    .apb_req_i(req), .apb_rsp_o(rsp), .chan_clk_o(chan_clk),
    .chan_clk_n_o(chan_clk_n), .chan_clk_oe_n_o(oe_n),
    .settled_o(settled), .locked_o(locked));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // 0 settled, 1 locked, else output enable
  task wait_until(input int which, input logic val, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge core_clk_i);
      case (which)
        0: s = settled;
        1: s = locked;
        default: s = oe_n;
      endcase
      if (s === val)
        break;
    end
    check({31'h0, s}, {31'h0, val});
  endtask : wait_until

  task measure(input logic [31:0] exp);
    int n;
    int e;
    logic prev;
    n = 0;
    e = 0;
    prev = chan_clk;
    while (e < 2 && n < 100)
    begin
      @(negedge core_clk_i);
      n++;
      if (chan_clk === 1'b1 && prev === 1'b0)
      begin
        e++;
        if (e == 1)
          n = 0;
      end
      prev = chan_clk;
    end
    check(n, exp);
  endtask : measure

  task pins_to(input logic p, input logic s);
    @(posedge core_clk_i);
    pd_n <= p;
    stop_n <= s;
  endtask : pins_to

  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0001);
    check({chan_clk, chan_clk_n, oe_n, settled, locked}, 5'h00);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, ADDR_STATUS, 32'h0000_0040);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({err, rd[30:0]}, 32'h0000_0001);
    $display("test reset_and_map done");

    pins_to(1'b1, 1'b0);
    repeat (WAKE_P + 8) @(posedge core_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[7:0], 32'h04);
    check({31'h0, oe_n}, 32'h1);
    pins_to(1'b1, 1'b1);
    wait_until(2, 1'b0, OUT_ENABLE_CYC + 4);
    wait_until(0, 1'b1, 40 * HALF_R0 + 8);
    check({31'h0, chan_clk_n}, {31'h0, ~chan_clk});
    wait_until(1, 1'b1, LOCK_P);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[9:7], 32'h3);
    $display("test wake_stop_lock done");

    pins_to(1'b1, 1'b0);
    wait_until(2, 1'b1, OUT_DISABLE_CYC + 4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[7:0], 32'h04);
    pins_to(1'b1, 1'b1);
    wait_until(0, 1'b1, 40 * HALF_R0 + 12);
    // aligner off so divider periods stay exact
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    for (int r = 1; r < 5; r++)
    begin
      @(posedge core_clk_i);
      ratio <= 2'(r);
      wait_until(0, 1'b0, 5);
      wait_until(0, 1'b1, RATIO_P + 220);
      measure(2 * halfs[r % 4]);
    end
    $display("test stop_and_ratio done");

    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    wait_until(0, 1'b0, 5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[7:0], 32'h01);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    wait_until(0, 1'b1, WAKE_P + 220);
    pins_to(1'b0, 1'b1);
    wait_until(0, 1'b0, 5);
    check({chan_clk, chan_clk_n, oe_n}, 3'h0);
    $display("test power_down done");

    for (int m = 1; m < 4; m++)
    begin
      repeat (4) @(posedge core_clk_i);
      mode <= 2'(m);
      repeat (4) @(posedge core_clk_i);
      pins_to(1'b1, 1'b1);
      wait_until(0, 1'b1, WAKE_P + 220);
      check({31'h0, oe_n}, {31'h0, m == 1});
      apb(1'b0, ADDR_PINS, 32'h0);
      check(rd[8:3], {2'h3, 2'h0, 2'(m)});
      pins_to(1'b0, 1'b1);
      wait_until(0, 1'b0, 5);
    end
    $display("test output_modes done");
    end_of_test();
  end
endmodule : clock_source_state_sequencer_bench
